// ---- tb/scr_link_sva.sv ----
module scr_link_sva
   import scr_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic alignment_event_i,
   input wire logic alignment_event_o,
   input wire logic power_down_o,
   input wire logic alignment_receiver_enable_o,
   input wire logic alignment_processor_enable_o,
   input wire logic alignment_window_fine_step_o,
   input wire logic [ALIGN_SEL_W-1:0] alignment_delay_select_o,
   input wire logic soft_reset_busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_event_pass: assert property (alignment_event_i && alignment_processor_enable_o &&
      alignment_receiver_enable_o |=> alignment_event_o) else $error("accepted event missing");
   a_event_cause: assert property (alignment_event_o |-> $past(alignment_event_i))
      else $error("event without input pulse");
   a_recv_off: assert property (!alignment_receiver_enable_o |=> !alignment_event_o)
      else $error("event passed with receiver off");
   a_proc_recv: assert property (alignment_processor_enable_o |-> alignment_receiver_enable_o)
      else $error("processor on without receiver");
   a_mode_quiet: assert property (cs_n && $past(cs_n, 8) |-> $stable(power_down_o))
      else $error("power down moved outside a frame");
   a_sel_quiet: assert property (cs_n && $past(cs_n, 8) |-> $stable(alignment_delay_select_o)
      && $stable(alignment_window_fine_step_o)) else $error("delay setting moved outside a frame");
   a_sdo_setup: assert property (!cs_n && $rose(sclk) |-> $stable(sdo))
      else $error("read data moved at sampling edge");
   a_sdi_setup: assert property (!cs_n && $rose(sclk) |-> $stable(sdi))
      else $error("write data moved at sampling edge");
   a_busy_min: assert property ($rose(soft_reset_busy_o) |-> soft_reset_busy_o[*4])
      else $error("soft reset too short");
   a_busy_end: assert property ($rose(soft_reset_busy_o) |-> ##[4:12] !soft_reset_busy_o)
      else $error("soft reset never ends");
   a_busy_clear: assert property (soft_reset_busy_o && $past(soft_reset_busy_o) |-> !power_down_o
      && !alignment_receiver_enable_o && alignment_delay_select_o == '0) else $error("outputs kept in reset");
   a_no_frame: assert property ($fell(cs_n) |-> !soft_reset_busy_o)
      else $error("frame started during soft reset");
endmodule

// ---- tb/test_spi_config_and_alignment_regs.sv ----
module test_spi_config_and_alignment_regs
   import scr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MAKER = 16'h7e21; // arbitrary value
   localparam int LIMIT = 20000;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [2:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic busy;
   logic [POS_W-1:0] pos;
   logic ev_i;
   logic ev_o;
   logic pd;
   logic recv;
   logic proc;
   logic fine;
   logic [ALIGN_SEL_W-1:0] sel;
   logic srb;
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   always #2.5 clk_i = ~clk_i;
   scr_link_if i_scr_link_if ();
   scr_link_if i_scr_link_if_b ();
   scr_ctrl #(.SCLK_HALF(3), .RESET_CYC(4)) i_scr_ctrl (.clk_i(clk_i), .reset_i(reset_i),
      .link(i_scr_link_if.ctrl), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .busy_o(busy));
   scr_dev #(.MAKER_ID(MAKER), .RESET_CYC(4)) i_scr_dev (.clk_i(clk_i), .reset_i(reset_i),
      .link(i_scr_link_if.dev), .alignment_edge_position_status_i(pos), .alignment_event_i(ev_i),
      .alignment_event_o(ev_o), .power_down_o(pd), .alignment_receiver_enable_o(recv),
      .alignment_processor_enable_o(proc), .alignment_window_fine_step_o(fine),
      .alignment_delay_select_o(sel), .soft_reset_busy_o(srb));
   // second device, link driven by the bench to reach streaming
   scr_dev #(.MAKER_ID(MAKER), .RESET_CYC(4)) i_scr_dev_b (.clk_i(clk_i), .reset_i(reset_i),
      .link(i_scr_link_if_b.dev), .alignment_edge_position_status_i(pos), .alignment_event_i(ev_i),
      .alignment_event_o(), .power_down_o(), .alignment_receiver_enable_o(),
      .alignment_processor_enable_o(), .alignment_window_fine_step_o(),
      .alignment_delay_select_o(), .soft_reset_busy_o());
   scr_link_sva i_scr_link_sva (.clk_i(clk_i), .reset_i(reset_i), .sclk(i_scr_link_if.sclk),
      .cs_n(i_scr_link_if.cs_n), .sdi(i_scr_link_if.sdi), .sdo(i_scr_link_if.sdo),
      .alignment_event_i(ev_i), .alignment_event_o(ev_o), .power_down_o(pd),
      .alignment_receiver_enable_o(recv), .alignment_processor_enable_o(proc),
      .alignment_window_fine_step_o(fine), .alignment_delay_select_o(sel), .soft_reset_busy_o(srb));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic xfer(input logic [14:0] a, input logic rw, input logic [7:0] d, output logic [7:0] q);
      int n;
      logic [15:0] r;
      bus_wr(HR_ADDR, {1'b0, a});
      bus_wr(HR_DATA, {8'h00, d});
      bus_wr(HR_CMD, {15'h0000, rw});
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (busy !== 1'b0 && n < 2000);
      bus_rd(HR_RDATA, r);
      q = r[7:0];
   endtask
   task automatic wreg(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(a, 1'b0, d, q);
   endtask
   task automatic rchk(input logic [14:0] a, input logic [7:0] e, input string s);
      logic [7:0] q;
      xfer(a, 1'b1, 8'h00, q);
      chk(s, {16'h0000, e}, {16'h0000, q});
   endtask
   task automatic pulse(output logic seen);
      @(posedge clk_i);
      ev_i <= 1'b1;
      @(posedge clk_i);
      ev_i <= 1'b0;
      #1;
      seen = ev_o;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_defaults();
      rchk(OFS_IFACE_CFG, 8'h30, "iface_cfg");
      rchk(OFS_OP_MODE, 8'h00, "op_mode");
      rchk(OFS_STREAM_OPT, 8'h00, "stream_opt");
      rchk(OFS_ALIGN_CLK, 8'h80, "align_clk");
      rchk(OFS_MAKER_LO, MAKER[7:0], "maker_lo");
      rchk(OFS_MAKER_HI, MAKER[15:8], "maker_hi");
      chk("recv", 24'h0, {23'h0, recv});
      chk("proc", 24'h0, {23'h0, proc});
   endtask
   task automatic t_cfg();
      wreg(OFS_IFACE_CFG, 8'h00);
      rchk(OFS_IFACE_CFG, 8'h10, "iface_rd");
      wreg(OFS_MAKER_LO, 8'hff);
      rchk(OFS_MAKER_LO, MAKER[7:0], "maker_ro");
      wreg(OFS_IFACE_CFG, 8'h30);
      // reserved bits asked for here must reach the device as defaults
      wreg(OFS_OP_MODE, 8'hfc);
      rchk(OFS_OP_MODE, 8'h00, "rsv_forced");
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wreg(OFS_OP_MODE, 8'(m));
         chk("power_down", {23'h0, m == 3}, {23'h0, pd});
         rchk(OFS_OP_MODE, 8'(m), "mode_rd");
      end
   endtask
   task automatic t_align();
      logic s;
      wreg(OFS_ALIGN_CLK, 8'h9a);
      chk("fine", 24'h1, {23'h0, fine});
      chk("sel", 24'ha, {20'h0, sel});
      pulse(s);
      chk("event_off", 24'h0, {23'h0, s});
      wreg(OFS_ALIGN_CLK, 8'hca);
      chk("recv_forced", 24'h1, {23'h0, recv});
      rchk(OFS_ALIGN_CLK, 8'hea, "align_rd");
      pulse(s);
      chk("event_on", 24'h1, {23'h0, s});
      wreg(OFS_ALIGN_CLK, 8'ha0);
      chk("fine_off", 24'h0, {23'h0, fine});
      pulse(s);
      chk("event_gated", 24'h0, {23'h0, s});
   endtask
   task automatic t_position();
      @(posedge clk_i);
      pos <= 24'ha5c31e;
      rchk(OFS_POS_0, 8'h1e, "pos0");
      rchk(OFS_POS_1, 8'hc3, "pos1");
      rchk(OFS_POS_2, 8'ha5, "pos2");
   endtask
   task automatic t_soft_reset();
      wreg(OFS_ALIGN_CLK, 8'he5);
      wreg(OFS_IFACE_CFG, 8'hb0);
      chk("pd_cleared", 24'h0, {23'h0, pd});
      rchk(OFS_IFACE_CFG, 8'h30, "self_clear");
      rchk(OFS_ALIGN_CLK, 8'h80, "align_rst");
      rchk(OFS_OP_MODE, 8'h00, "mode_rst");
   endtask
   // ----------------------------------------
   // bench-driven streaming frames
   // ----------------------------------------
   task automatic sbyte(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         i_scr_link_if_b.sdi <= d[i];
         repeat (3) @(posedge clk_i);
         i_scr_link_if_b.sclk <= 1'b1;
         q = {q[6:0], i_scr_link_if_b.sdo};
         repeat (3) @(posedge clk_i);
         i_scr_link_if_b.sclk <= 1'b0;
      end
   endtask
   task automatic sframe(input logic [15:0] h, input logic [7:0] d, input logic two, output logic [15:0] q);
      logic [7:0] x;
      @(posedge clk_i);
      i_scr_link_if_b.cs_n <= 1'b0;
      sbyte(h[15:8], x);
      sbyte(h[7:0], x);
      sbyte(d, q[15:8]);
      if (two) begin
         sbyte(d, q[7:0]);
      end
      repeat (3) @(posedge clk_i);
      i_scr_link_if_b.cs_n <= 1'b1;
      // idle data line must not look like a held bit
      i_scr_link_if_b.sdi <= ~d[0];
      repeat (3) @(posedge clk_i);
   endtask
   task automatic t_stream();
      logic [15:0] q;
      sframe({1'b1, OFS_MAKER_LO}, 8'h00, 1'b1, q);
      chk("stream_up", {8'h0, MAKER[7:0], MAKER[15:8]}, {8'h0, q});
      sframe({1'b0, OFS_IFACE_CFG}, 8'h00, 1'b0, q);
      sframe({1'b1, OFS_MAKER_HI}, 8'h00, 1'b1, q);
      chk("stream_down", {8'h0, MAKER}, {8'h0, q});
      sframe({1'b0, OFS_STREAM_OPT}, 8'h01, 1'b0, q);
      sframe({1'b1, OFS_MAKER_LO}, 8'h00, 1'b1, q);
      chk("stream_hold", {8'h0, MAKER[7:0], MAKER[7:0]}, {8'h0, q});
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      pos = '0;
      ev_i = 1'b0;
      i_scr_link_if_b.sclk = 1'b0;
      i_scr_link_if_b.cs_n = 1'b1;
      i_scr_link_if_b.sdi = 1'b0;
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      t_defaults();
      t_cfg();
      t_modes();
      t_align();
      t_position();
      t_soft_reset();
      t_stream();
      end_of_test();
   end
endmodule

// ---- verilog/scr_addr_step.sv ----
module scr_addr_step
   import scr_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   input wire logic [AW-1:0] addr_i,
   input wire logic hold_i,
   input wire logic ascend_i,
   output logic [AW-1:0] addr_o
);
   if (AW < 1) begin : g_chk
      $error("scr_addr_step: AW must be at least 1");
   end

   always_comb begin
      if (hold_i) begin
         addr_o = addr_i;
      end else if (ascend_i) begin
         addr_o = addr_i + 1'b1;
      end else begin
         addr_o = addr_i - 1'b1;
      end
   end
endmodule

// ---- verilog/scr_ctrl.sv ----
module scr_ctrl
   import scr_pkg::*;
#(
   parameter int SCLK_HALF = SCLK_HALF_DEF,
   parameter int RESET_CYC = SOFT_RESET_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   scr_link_if.ctrl link,
   input wire logic [2:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   output logic busy_o
);
   if (SCLK_HALF < 3 || SCLK_HALF > 255 || RESET_CYC < 1 || RESET_CYC > 65535) begin : g_chk
      $error("scr_ctrl: SCLK_HALF or RESET_CYC out of range");
   end

   typedef enum logic [1:0] {
      HS_IDLE,
      HS_SHIFT,
      HS_GAP
   } scr_ctrl_state_t;

   typedef struct packed {
      scr_ctrl_state_t st;
      logic [7:0] div;
      logic [4:0] bits;
      logic sclk;
      logic cs_n;
      logic sdi;
      logic [FRAME_W-1:0] sh;
      logic [7:0] rx;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
      logic [7:0] rbyte;
      logic sr_wait;
      logic [15:0] wait_cnt;
      logic [15:0] rdq;
      logic busy;
   } scr_ctrl_regs_t;

   localparam scr_ctrl_regs_t CTRL_RST = '{
      st: HS_IDLE, div: 8'h00, bits: 5'h00, sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0,
      sh: 24'h000000, rx: 8'h00, addr: 15'h0000, data: 8'h00, rbyte: 8'h00,
      sr_wait: 1'b0, wait_cnt: 16'h0000, rdq: 16'h0000, busy: 1'b0
   };

   scr_ctrl_regs_t s;
   scr_ctrl_regs_t n;
   logic [7:0] wbyte;

   // ----------------------------------------
   // reserved fields forced to defaults
   // ----------------------------------------
   always_comb begin
      wbyte = s.data;
      unique case (s.addr)
         OFS_IFACE_CFG: wbyte = (s.data & ~RSV_IFACE_CFG) | (RST_IFACE_CFG & RSV_IFACE_CFG);
         OFS_OP_MODE: wbyte = (s.data & ~RSV_OP_MODE) | (RST_OP_MODE & RSV_OP_MODE);
         OFS_STREAM_OPT: wbyte = (s.data & ~RSV_STREAM_OPT) | (RST_STREAM_OPT & RSV_STREAM_OPT);
         OFS_ALIGN_CLK: begin
            wbyte = (s.data & ~RSV_ALIGN_CLK) | (RST_ALIGN_CLK & RSV_ALIGN_CLK);
            // receiver comes up in the same write as the processor at the latest
            if (s.data[ALIGN_PROC_EN]) begin
               wbyte[ALIGN_RECV_EN] = 1'b1;
            end
         end
         default: ;
      endcase
   end

   always_comb begin
      n = s;
      n.rdq = 16'h0000;
      if (rd_i) begin
         unique case (addr_i)
            HR_ADDR: n.rdq = {1'b0, s.addr};
            HR_DATA: n.rdq = {8'h00, s.data};
            HR_STATUS: n.rdq = {15'h0000, s.busy};
            HR_RDATA: n.rdq = {8'h00, s.rbyte};
            default: n.rdq = 16'h0000;
         endcase
      end
      if (wr_i && addr_i == HR_ADDR) begin
         n.addr = wdata_i[ADDR_W-1:0];
      end
      if (wr_i && addr_i == HR_DATA) begin
         n.data = wdata_i[7:0];
      end
      unique case (s.st)
         HS_IDLE: begin
            if (wr_i && addr_i == HR_CMD) begin
               n.st = HS_SHIFT;
               n.sh = {wdata_i[CMD_READ], s.addr, wbyte};
               n.sdi = wdata_i[CMD_READ];
               n.cs_n = 1'b0;
               n.div = 8'h00;
               n.bits = 5'h00;
               n.sr_wait = !wdata_i[CMD_READ] && s.addr == OFS_IFACE_CFG && s.data[IFC_SOFT_RESET];
            end
         end
         HS_SHIFT: begin
            n.div = s.div + 8'h01;
            if (s.div == 8'(SCLK_HALF - 1)) begin
               n.div = 8'h00;
               n.sclk = !s.sclk;
               if (!s.sclk) begin
                  n.rx = {s.rx[6:0], link.sdo};
               end else if (s.bits == 5'(FRAME_W - 1)) begin
                  n.st = HS_GAP;
                  n.cs_n = 1'b1;
                  n.wait_cnt = 16'h0000;
               end else begin
                  n.bits = s.bits + 5'h01;
                  n.sh = {s.sh[FRAME_W-2:0], 1'b0};
                  n.sdi = s.sh[FRAME_W-2];
               end
            end
         end
         HS_GAP: begin
            n.wait_cnt = s.wait_cnt + 16'h0001;
            // the device ignores the link while it resets itself
            if ((s.sr_wait && s.wait_cnt == 16'(RESET_CYC - 1)) ||
                (!s.sr_wait && s.wait_cnt == 16'(SCLK_HALF - 1))) begin
               n.st = HS_IDLE;
               n.rbyte = s.rx;
               n.sdi = 1'b0;
            end
         end
         default: n.st = HS_IDLE;
      endcase
      n.busy = n.st != HS_IDLE;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s <= CTRL_RST;
      end else begin
         s <= n;
      end
   end

   assign link.sclk = s.sclk;
   assign link.cs_n = s.cs_n;
   assign link.sdi = s.sdi;
   assign rdata_o = s.rdq;
   assign busy_o = s.busy;
endmodule

// ---- verilog/scr_dev.sv ----
module scr_dev
   import scr_pkg::*;
#(
   parameter logic [MAKER_W-1:0] MAKER_ID = 16'h5a3c, // arbitrary value
   parameter int RESET_CYC = SOFT_RESET_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   scr_link_if.dev link,
   input wire logic [POS_W-1:0] alignment_edge_position_status_i,
   input wire logic alignment_event_i,
   output logic alignment_event_o,
   output logic power_down_o,
   output logic alignment_receiver_enable_o,
   output logic alignment_processor_enable_o,
   output logic alignment_window_fine_step_o,
   output logic [ALIGN_SEL_W-1:0] alignment_delay_select_o,
   output logic soft_reset_busy_o
);
   if (RESET_CYC < 1 || RESET_CYC >= 2 ** RST_CNT_W) begin : g_chk
      $error("scr_dev: RESET_CYC out of range");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [1:0] {
      DV_IDLE,
      DV_HEADER,
      DV_DATA,
      DV_RESET
   } scr_dev_state_t;

   typedef struct packed {
      scr_dev_state_t st;
      logic sclk_q;
      logic [4:0] cnt;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [7:0] rx;
      logic [7:0] tx;
      logic sdo;
      logic [RST_CNT_W-1:0] rst_cnt;
      logic [7:0] ifc;
      logic [7:0] opm;
      logic [7:0] stopt;
      logic [7:0] aclk;
      logic pd;
      logic evt;
      logic busy;
   } scr_dev_regs_t;

   localparam scr_dev_regs_t DEV_RST = '{
      st: DV_IDLE,
      sclk_q: 1'b0,
      cnt: 5'h00,
      rd: 1'b0,
      addr: 15'h0000,
      rx: 8'h00,
      tx: 8'h00,
      sdo: 1'b0,
      rst_cnt: 8'h00,
      ifc: RST_IFACE_CFG,
      opm: RST_OP_MODE,
      stopt: RST_STREAM_OPT,
      aclk: RST_ALIGN_CLK,
      pd: 1'b0,
      evt: 1'b0,
      busy: 1'b0
   };

   scr_dev_regs_t s;
   scr_dev_regs_t n;
   logic rise;
   logic fall;
   logic [ADDR_W-1:0] hdr_addr;
   logic [7:0] wb;
   logic [ADDR_W-1:0] step_addr;

   assign rise = link.sclk & ~s.sclk_q;
   assign fall = ~link.sclk & s.sclk_q;
   assign hdr_addr = {s.addr[ADDR_W-2:0], link.sdi};
   assign wb = {s.rx[6:0], link.sdi};

   scr_addr_step #(
      .AW(ADDR_W)
   ) u_step (
      .addr_i(s.addr),
      .hold_i(s.stopt[STREAM_HOLD]),
      .ascend_i(s.ifc[IFC_ASCEND]),
      .addr_o(step_addr)
   );

   // ----------------------------------------
   // read view
   // ----------------------------------------
   function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         OFS_IFACE_CFG: v = s.ifc | (8'h01 << IFC_FOUR_WIRE);
         OFS_OP_MODE: v = s.opm;
         OFS_MAKER_LO: v = MAKER_ID[7:0];
         OFS_MAKER_HI: v = MAKER_ID[15:8];
         OFS_STREAM_OPT: v = s.stopt;
         OFS_ALIGN_CLK: v = s.aclk;
         OFS_POS_0: v = alignment_edge_position_status_i[7:0];
         OFS_POS_1: v = alignment_edge_position_status_i[15:8];
         OFS_POS_2: v = alignment_edge_position_status_i[23:16];
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = s;
      n.sclk_q = link.sclk;
      n.pd = s.opm[MODE_LSB +: MODE_W] == MODE_POWER_DOWN;
      // both enables needed: a disabled receiver delivers nothing to act on
      n.evt = alignment_event_i & s.aclk[ALIGN_PROC_EN] & s.aclk[ALIGN_RECV_EN];
      unique case (s.st)
         DV_IDLE: begin
            if (!link.cs_n) begin
               n.st = DV_HEADER;
               n.cnt = 5'h00;
            end
         end
         DV_HEADER: begin
            if (link.cs_n) begin
               n.st = DV_IDLE;
            end else if (rise) begin
               {n.rd, n.addr} = {s.addr, link.sdi};
               n.cnt = s.cnt + 5'h01;
               if (s.cnt == 5'(HDR_W - 1)) begin
                  n.st = DV_DATA;
                  n.cnt = 5'h00;
                  n.tx = rd_byte(hdr_addr);
               end
            end
         end
         DV_DATA: begin
            if (link.cs_n) begin
               n.st = DV_IDLE;
            end else if (fall) begin
               n.sdo = s.tx[7];
               n.tx = {s.tx[6:0], 1'b0};
            end else if (rise) begin
               n.rx = wb;
               n.cnt = s.cnt + 5'h01;
               if (s.cnt == 5'(BYTE_W - 1)) begin
                  n.cnt = 5'h00;
                  n.addr = step_addr;
                  n.tx = rd_byte(step_addr);
                  if (!s.rd) begin
                     unique case (s.addr)
                        OFS_IFACE_CFG: begin
                           if (wb[IFC_SOFT_RESET]) begin
                              // whole bank back to reset; bit never stored
                              n = DEV_RST;
                              n.st = DV_RESET;
                           end else begin
                              n.ifc = wb & ~(8'h01 << IFC_FOUR_WIRE);
                           end
                        end
                        OFS_OP_MODE: n.opm = wb;
                        OFS_STREAM_OPT: n.stopt = wb;
                        OFS_ALIGN_CLK: n.aclk = wb;
                        default: ;
                     endcase
                  end
               end
            end
         end
         DV_RESET: begin
            // link ignored until the reset time has run and the frame ended
            if (s.rst_cnt != RST_CNT_W'(RESET_CYC - 1)) begin
               n.rst_cnt = s.rst_cnt + 1'b1;
            end else if (link.cs_n) begin
               n.st = DV_IDLE;
            end
         end
      endcase
      n.busy = n.st == DV_RESET;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s <= DEV_RST;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign link.sdo = s.sdo;
   assign alignment_event_o = s.evt;
   assign power_down_o = s.pd;
   assign alignment_receiver_enable_o = s.aclk[ALIGN_RECV_EN];
   assign alignment_processor_enable_o = s.aclk[ALIGN_PROC_EN];
   assign alignment_window_fine_step_o = s.aclk[ALIGN_FINE];
   assign alignment_delay_select_o = s.aclk[ALIGN_SEL_LSB +: ALIGN_SEL_W];
   assign soft_reset_busy_o = s.busy;
endmodule

// ---- verilog/scr_link_if.sv ----
interface scr_link_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   // four-wire only: sdo is a plain output, never shared with sdi
   modport ctrl (output sclk, output cs_n, output sdi, input sdo);
   modport dev (input sclk, input cs_n, input sdi, output sdo);
endinterface

// ---- verilog/scr_pkg.sv ----
package scr_pkg;
   // ----------------------------------------
   // link framing
   // ----------------------------------------
   localparam int ADDR_W = 15;
   localparam int HDR_W = 16;
   localparam int BYTE_W = 8;
   localparam int FRAME_W = HDR_W + BYTE_W;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_IFACE_CFG = 15'h0000;
   localparam logic [ADDR_W-1:0] OFS_OP_MODE = 15'h0002;
   localparam logic [ADDR_W-1:0] OFS_MAKER_LO = 15'h000c;
   localparam logic [ADDR_W-1:0] OFS_MAKER_HI = 15'h000d;
   localparam logic [ADDR_W-1:0] OFS_STREAM_OPT = 15'h0010;
   localparam logic [ADDR_W-1:0] OFS_ALIGN_CLK = 15'h0029;
   localparam logic [ADDR_W-1:0] OFS_POS_0 = 15'h002c;
   localparam logic [ADDR_W-1:0] OFS_POS_1 = 15'h002d;
   localparam logic [ADDR_W-1:0] OFS_POS_2 = 15'h002e;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int IFC_SOFT_RESET = 7;
   localparam int IFC_ASCEND = 5;
   localparam int IFC_FOUR_WIRE = 4;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 2;
   localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h0;
   localparam logic [MODE_W-1:0] MODE_POWER_DOWN = 2'h3;
   localparam int STREAM_HOLD = 0;
   localparam int ALIGN_PROC_EN = 6;
   localparam int ALIGN_RECV_EN = 5;
   localparam int ALIGN_FINE = 4;
   localparam int ALIGN_SEL_LSB = 0;
   localparam int ALIGN_SEL_W = 4;
   localparam int POS_W = 24;
   localparam int MAKER_W = 16;

   // ----------------------------------------
   // reset values and reserved masks
   // ----------------------------------------
   localparam logic [7:0] RST_IFACE_CFG = 8'h30;
   localparam logic [7:0] RST_OP_MODE = 8'h00;
   localparam logic [7:0] RST_STREAM_OPT = 8'h00;
   localparam logic [7:0] RST_ALIGN_CLK = 8'h80;
   localparam logic [7:0] RSV_IFACE_CFG = 8'h4f;
   localparam logic [7:0] RSV_OP_MODE = 8'hfc;
   localparam logic [7:0] RSV_STREAM_OPT = 8'hfe;
   localparam logic [7:0] RSV_ALIGN_CLK = 8'h80;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SOFT_RESET_NS = 750;
   localparam int SOFT_RESET_CYC = (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RST_CNT_W = 8;
   localparam int SCLK_HALF_DEF = 4;

   // ----------------------------------------
   // controller register map
   // ----------------------------------------
   localparam logic [2:0] HR_ADDR = 3'h0;
   localparam logic [2:0] HR_DATA = 3'h1;
   localparam logic [2:0] HR_CMD = 3'h2;
   localparam logic [2:0] HR_STATUS = 3'h3;
   localparam logic [2:0] HR_RDATA = 3'h4;
   localparam int CMD_READ = 0;
endpackage
